// *** inc/tmsel_pkg.sv ***
// Register map, field layout and mode types of the timer mode selector.
package tmsel_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] AMODE_OFS = 8'h04;
	localparam logic [7:0] BMODE_OFS = 8'h08;
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int CAP_BIT = 2;
	localparam int ALT_BIT = 3;
	localparam int MREG_MSB = 3;
	localparam int CFG_MSB = 2;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [2:0] CFG_RST = 3'h0;
	localparam logic [2:0] CFG_32BIT = 3'h0;
	localparam logic [1:0] MODE_RSVD = 2'h0;
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam logic [1:0] MODE_CAPTURE = 2'h3;

	typedef struct packed {
		logic alt;
		logic cap;
		logic [1:0] mode;
	} tmsel_mreg_t;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ONESHOT,
		OP_PERIODIC,
		OP_CAP_COUNT,
		OP_CAP_TIME,
		OP_PWM
	} tmsel_op_t;
endpackage

// *** rtl/tmsel_decode.sv ***
// Turns one half's mode register into the operation that half performs.
module tmsel_decode
	import tmsel_pkg::*;
(
	input wire tmsel_mreg_t mreg,
	input wire logic in_use,
	output tmsel_op_t op
);
	always_comb
	begin
		op = OP_NONE;
		if (in_use)
		begin
			unique case (mreg.mode)
				MODE_RSVD: op = OP_NONE;
				MODE_ONESHOT: op = OP_ONESHOT;
				MODE_PERIODIC: op = mreg.alt ? OP_PWM : OP_PERIODIC;
				MODE_CAPTURE:
				begin
					if (mreg.alt)
						op = OP_PWM;
					else if (mreg.cap)
						op = OP_CAP_TIME;
					else
						op = OP_CAP_COUNT;
				end
			endcase
		end
	end
endmodule

// *** rtl/tmsel_top.sv ***
// Mode registers of a dual-half timer with their Avalon-MM slave.
//
// Implementation choice: the Avalon-MM register port.

module tmsel_top
	import tmsel_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic wide_mode,
	output tmsel_op_t half_a_op,
	output tmsel_op_t half_b_op
);
	logic ack_q;
	logic req;
	logic wr_go;
	logic [31:0] rdata_d;
	logic [31:0] readdata_q;
	logic [CFG_MSB:0] cfg_q;
	tmsel_mreg_t mreg_q [2];
	tmsel_op_t op_d [2];
	tmsel_op_t op_q [2];
	logic wide_q;

	// Each access is held for exactly one wait cycle, then completes.
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_go = avs_write & ack_q & avs_byteenable[0];

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			cfg_q <= CFG_RST;
		else if (wr_go && avs_address == CFG_OFS)
			cfg_q <= avs_writedata[CFG_MSB:0];
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			mreg_q[0] <= tmsel_mreg_t'(MODE_RST);
		else if (wr_go && avs_address == AMODE_OFS)
			mreg_q[0] <= tmsel_mreg_t'(avs_writedata[MREG_MSB:0]);
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			mreg_q[1] <= tmsel_mreg_t'(MODE_RST);
		else if (wr_go && avs_address == BMODE_OFS)
			mreg_q[1] <= tmsel_mreg_t'(avs_writedata[MREG_MSB:0]);
	end

	// Reserved and unmapped locations read as zero.
	always_comb
	begin
		rdata_d = 32'h00000000;
		unique case (avs_address)
			CFG_OFS: rdata_d[CFG_MSB:0] = cfg_q;
			AMODE_OFS: rdata_d[MREG_MSB:0] = mreg_q[0];
			BMODE_OFS: rdata_d[MREG_MSB:0] = mreg_q[1];
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			readdata_q <= 32'h00000000;
		else if (avs_read && !ack_q)
			readdata_q <= rdata_d;
	end

	assign avs_readdata = readdata_q;

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		// The flag resets to match the reset width setting; after reset it follows cfg_q one cycle late.
		if (!rst_b)
			wide_q <= (CFG_RST == CFG_32BIT);
		else
			wide_q <= (cfg_q == CFG_32BIT);
	end

	assign wide_mode = wide_q;

	// The second half is only in use when the timer is split.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_half
			tmsel_decode u_dec (
				.mreg(mreg_q[gi]),
				.in_use((gi == 0) || (cfg_q != CFG_32BIT)),
				.op(op_d[gi])
			);

			always_ff @(posedge sys_clk or negedge rst_b)
			begin
				if (!rst_b)
					op_q[gi] <= OP_NONE;
				else
					op_q[gi] <= op_d[gi];
			end
		end
	endgenerate

	assign half_a_op = op_q[0];
	assign half_b_op = op_q[1];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_req_open;
		req && !ack_q;
	endsequence

	sequence s_req_done;
		!avs_waitrequest ##1 !ack_q;
	endsequence

	sequence s_lane_off;
		avs_write && ack_q && !avs_byteenable[0];
	endsequence

	bus_wait_one_a: assert property (
		s_req_open |=> s_req_done)
		else $error("access did not finish after one wait cycle");

	upper_zero_a: assert property (
		avs_read && ack_q |-> avs_readdata[31:4] == 28'h0000000)
		else $error("reserved mode bits read nonzero");

	bmode_write_a: assert property (
		wr_go && avs_address == BMODE_OFS
		|=> mreg_q[1] == $past(avs_writedata[3:0]))
		else $error("second-half register missed a write");

	bmode_readback_a: assert property (
		avs_read && !ack_q && avs_address == BMODE_OFS
		|=> avs_readdata[3:0] == $past(mreg_q[1]))
		else $error("second-half register read back wrong");

	a_oneshot_a: assert property (
		mreg_q[0].mode == MODE_ONESHOT && !mreg_q[0].alt
		|=> half_a_op == OP_ONESHOT)
		else $error("first half not one-shot");

	a_reserved_a: assert property (
		mreg_q[0].mode == MODE_RSVD |=> half_a_op == OP_NONE)
		else $error("reserved mode gave an operation");

	wide_ignores_b_a: assert property (
		cfg_q == CFG_32BIT |=> half_b_op == OP_NONE && wide_mode)
		else $error("second half active in 32-bit operation");

	split_b_periodic_a: assert property (
		cfg_q != CFG_32BIT && mreg_q[1].mode == MODE_PERIODIC
		&& !mreg_q[1].alt |=> half_b_op == OP_PERIODIC)
		else $error("split second half not periodic");

	pwm_select_a: assert property (
		cfg_q != CFG_32BIT && mreg_q[1] == 4'hA |=> half_b_op == OP_PWM)
		else $error("pulse-width setting not taken");

	capture_edge_a: assert property (
		mreg_q[0].mode == MODE_CAPTURE && !mreg_q[0].alt
		&& !mreg_q[0].cap |=> half_a_op == OP_CAP_COUNT)
		else $error("capture variant wrong");

	a_cap_time_a: assert property (
		mreg_q[0].mode == MODE_CAPTURE && !mreg_q[0].alt
		&& mreg_q[0].cap |=> half_a_op == OP_CAP_TIME)
		else $error("first half capture not edge timing");

	b_cap_time_a: assert property (
		cfg_q != CFG_32BIT && mreg_q[1].mode == MODE_CAPTURE
		&& mreg_q[1][3:2] == 2'h1 |=> half_b_op == OP_CAP_TIME)
		else $error("second half capture not edge timing");

	b_alt_capture_a: assert property (
		cfg_q != CFG_32BIT && mreg_q[1].mode == MODE_CAPTURE
		&& mreg_q[1].alt |=> half_b_op == OP_PWM)
		else $error("alternate select did not give pulse-width");

	a_periodic_a: assert property (
		mreg_q[0].mode == MODE_PERIODIC && !mreg_q[0].alt
		|=> half_a_op == OP_PERIODIC)
		else $error("first half not periodic");

	wide_flag_split_a: assert property (
		cfg_q != CFG_32BIT |=> !wide_mode)
		else $error("width flag set while split");

	cfg_write_a: assert property (
		wr_go && avs_address == CFG_OFS
		|=> cfg_q == $past(avs_writedata[2:0]))
		else $error("width setting missed a write");

	amode_write_a: assert property (
		wr_go && avs_address == AMODE_OFS
		|=> mreg_q[0] == $past(avs_writedata[3:0]))
		else $error("first-half register missed a write");

	lane_off_a: assert property (
		s_lane_off |=> $stable(mreg_q[1]) && $stable(mreg_q[0]))
		else $error("write with lane 0 off changed a mode register");
endmodule

// *** bench/tmsel_top_bench.sv ***
// Self-checking bench for the timer mode selector over its Avalon-MM port.
module tmsel_top_bench
	import tmsel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic wide_mode;
	tmsel_op_t half_a_op;
	tmsel_op_t half_b_op;
	logic [31:0] rdv;
	int fail_count = 0;
	int total_checks = 0;
	logic [3:0] bv [7] = '{4'h3, 4'h7, 4'hA, 4'hB, 4'h2, 4'h9, 4'h0};
	tmsel_op_t bo [7] = '{OP_CAP_COUNT, OP_CAP_TIME, OP_PWM, OP_PWM,
		OP_PERIODIC, OP_ONESHOT, OP_NONE};
	tmsel_op_t ao [4] = '{OP_NONE, OP_ONESHOT, OP_PERIODIC, OP_CAP_COUNT};

	tmsel_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .wide_mode(wide_mode),
		.half_a_op(half_a_op), .half_b_op(half_b_op));

	always #50 sys_clk = ~sys_clk;

	task automatic results();
		$display("Checks %0d, errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic chk_op(input string nm, input tmsel_op_t e,
		input tmsel_op_t g);
		total_checks++;
		if (g !== e)
		begin
			$display("Error %s expected %0d seen %0d", nm, e, g);
			fail_count++;
		end
	endtask

	// One bus cycle; the request is held until waitrequest is seen low.
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= b;
		avs_write <= w;
		avs_read <= !w;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
		begin
			$display("Error waitrequest expected 0 seen %b", avs_waitrequest);
			fail_count++;
			results();
		end
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge sys_clk);
	endtask

	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		acc(0, BMODE_OFS, 0, 4'hF);
		chk("b_mode_reset", 0, rdv);
		acc(0, AMODE_OFS, 0, 4'hF);
		chk("a_mode_reset", 0, rdv);
		chk("wide_reset", 1, wide_mode);
		acc(1, BMODE_OFS, 32'hFFFFFFFF, 4'hF);
		acc(0, BMODE_OFS, 0, 4'hF);
		chk("b_mode_rsvd", 32'h0000000F, rdv);
		settle();
		chk_op("b_op_wide", OP_NONE, half_b_op);
		for (int m = 0; m < 4; m++)
		begin
			acc(1, AMODE_OFS, m, 4'hF);
			settle();
			chk_op("a_op_wide", ao[m], half_a_op);
		end
		acc(1, CFG_OFS, 32'h1, 4'hF);
		settle();
		chk("wide_split", 0, wide_mode);
		for (int i = 0; i < 7; i++)
		begin
			acc(1, BMODE_OFS, bv[i], 4'hF);
			settle();
			chk_op("b_op_split", bo[i], half_b_op);
			chk_op("a_op_split", OP_CAP_COUNT, half_a_op);
		end
		acc(1, AMODE_OFS, 32'h7, 4'hF);
		settle();
		chk_op("a_cap_time", OP_CAP_TIME, half_a_op);
		acc(1, BMODE_OFS, 32'hA, 4'hF);
		settle();
		chk_op("b_pwm", OP_PWM, half_b_op);
		acc(1, BMODE_OFS, 32'h5, 4'hE);
		acc(0, BMODE_OFS, 0, 4'hF);
		chk("b_lane_off", 32'hA, rdv);
		acc(0, 8'hFC, 0, 4'hF);
		chk("unmapped", 0, rdv);
		acc(1, AMODE_OFS, 32'hB, 4'hF);
		settle();
		chk_op("a_pwm", OP_PWM, half_a_op);
		acc(1, CFG_OFS, 32'h0, 4'hF);
		settle();
		chk_op("b_op_ignored", OP_NONE, half_b_op);
		chk_op("a_op_governs", OP_PWM, half_a_op);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		chk_op("a_op_rst", OP_NONE, half_a_op);
		chk_op("b_op_rst", OP_NONE, half_b_op);
		chk("wide_rst", 1, wide_mode);
		acc(0, BMODE_OFS, 0, 4'hF);
		chk("b_mode_rst", 0, rdv);
		acc(0, AMODE_OFS, 0, 4'hF);
		chk("a_mode_rst", 0, rdv);
		results();
	end
endmodule
